// ===== rtl/poh_pkg.sv
// poh_pkg: constants and carrier types for the path overhead byte bank
package poh_pkg;
  // ---------------------------------------------------------------
  // register offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] ADR_GROWTH_A = 8'h6D;
  localparam logic [7:0] ADR_GROWTH_B = 8'h6E;
  localparam logic [7:0] ADR_GROWTH_C = 8'h6F;
  localparam logic [7:0] ADR_EXP_LABEL = 8'h75;
  localparam logic [7:0] ADR_RX_PARITY = 8'h78;
  localparam logic [7:0] ADR_RX_LABEL = 8'h79;
  localparam logic [7:0] ADR_RX_STATUS = 8'h7A;
  localparam logic [7:0] ADR_TRACE_LO = 8'h80;
  localparam logic [7:0] ADR_TRACE_HI = 8'hBF;
  localparam logic [7:0] ADR_BITERR_LO = 8'h40;
  localparam logic [7:0] ADR_BITERR_HI = 8'h41;
  localparam logic [7:0] ADR_BLKERR = 8'h4A;
  // ---------------------------------------------------------------
  // sizes, reset values and field positions
  // ---------------------------------------------------------------
  localparam int TRACE_LONG = 64;
  localparam int TRACE_SHORT = 16;
  localparam logic [7:0] BYTE_RST = 8'h00;
  localparam logic [15:0] BITERR_RST = 16'h0000;
  localparam logic [15:0] BITERR_MAX = 16'hFFFF;
  localparam logic [7:0] BLKERR_MAX = 8'hFF;
  localparam int STAT_FEBE_HI = 7;
  localparam int STAT_FEBE_LO = 4;
  localparam int STAT_RDI = 3;
  localparam int STAT_SPARE_HI = 2;
  // ---------------------------------------------------------------
  // carrier types
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    POH_SLOT_NONE = 3'b000,
    POH_SLOT_GA = 3'b001,
    POH_SLOT_GB = 3'b010,
    POH_SLOT_GC = 3'b011,
    POH_SLOT_TRACE = 3'b100
  } poh_slot_t;
  typedef enum logic [1:0] {
    POH_RX_PARITY = 2'b00,
    POH_RX_LABEL = 2'b01,
    POH_RX_STATUS = 2'b10
  } poh_rx_kind_t;
  // add-side request: which byte slot, plus the external byte
  typedef struct packed {
    poh_slot_t slot;
    logic [7:0] ext_byte;
  } poh_add_req_t;
  // byte leaving toward the add bus
  typedef struct packed {
    poh_slot_t slot;
    logic [7:0] data;
  } poh_add_out_t;
  // drop-side byte with locally computed parity for the check
  typedef struct packed {
    logic valid;
    poh_rx_kind_t kind;
    logic [7:0] data;
    logic [7:0] calc_parity;
  } poh_drop_t;
endpackage

// ===== rtl/poh_bank.sv
// poh_bank: path overhead byte store, add-side inserter, drop capture
//
// Summary of operation
// - growth byte a: processor, external, or captured
// - growth byte b: same three-way source choice
// - growth byte c: same three-way source choice
// - register bit 7 is sent first
// - trace store holds 64 or 16 bytes
// - trace sent cyclically, one byte per frame
// - trace stream uses same three-way choice
// - overhead work only while disable pin high
// - flag mismatch of received and expected label
// - received parity byte stored every frame
// - parity bit errors in 16-bit counter
// - block error counter bumps once per parity byte with bit errors
// - received label byte captured every frame
// - received status byte captured every frame
// - received bit 7 is first frame bit
// - status fields: febe, rdi, unassigned bits
`timescale 1ns/1ps
`default_nettype none
module poh_bank #(
  parameter int TRACE_DEPTH = poh_pkg::TRACE_LONG
) (
  input wire logic mclk_i,
  input wire logic rst_b_i,
  // processor port
  input wire logic [7:0] cpu_addr_i,
  input wire logic [7:0] cpu_wdata_i,
  input wire logic cpu_wr_i,
  input wire logic cpu_rd_i,
  output logic [7:0] cpu_rdata_o,
  // control levels
  input wire logic ext_growth_a_sel_i,
  input wire logic ext_growth_b_sel_i,
  input wire logic ext_growth_c_sel_i,
  input wire logic ext_trace_sel_i,
  input wire logic overhead_capture_to_ram_i,
  input wire logic trace_length_select_i,
  input wire logic overhead_disable_pin_i,
  // add side
  input wire poh_pkg::poh_add_req_t add_req_i,
  input wire logic add_req_valid_i,
  output logic add_req_ready_o,
  output poh_pkg::poh_add_out_t add_out_o,
  output logic add_out_valid_o,
  input wire logic add_out_ready_i,
  // drop side
  input wire poh_pkg::poh_drop_t drop_i,
  output logic label_mismatch_o,
  output logic [3:0] rx_febe_o,
  output logic rx_rdi_o
);
  import poh_pkg::*;
  localparam int PW = $clog2(TRACE_DEPTH);

  // ---------------------------------------------------------------
  // pin synchroniser
  // ---------------------------------------------------------------
  logic en_meta_ff;
  logic en_ff;

  // first stage is read only by the second
  always_ff @(posedge mclk_i) begin
    if (!rst_b_i) begin
      en_meta_ff <= 1'b0;
      en_ff <= 1'b0;
    end else begin
      en_meta_ff <= overhead_disable_pin_i;
      en_ff <= en_meta_ff;
    end
  end

  // ---------------------------------------------------------------
  // processor write decode
  // ---------------------------------------------------------------
  logic [7:0] growth_a_ff;
  logic [7:0] growth_b_ff;
  logic [7:0] growth_c_ff;
  logic [7:0] exp_label_ff;
  logic [7:0] trace_mem [TRACE_DEPTH];
  logic [PW-1:0] trace_ptr_ff;
  logic [PW-1:0] nxt_trace_ptr;
  logic trace_hit;
  logic [PW-1:0] trace_wofs;

  assign trace_hit = (cpu_addr_i >= ADR_TRACE_LO) &&
                     (cpu_addr_i <= ADR_TRACE_HI);
  assign trace_wofs = PW'(cpu_addr_i - ADR_TRACE_LO);

  // ---------------------------------------------------------------
  // add-side source selection
  // ---------------------------------------------------------------
  logic take;
  logic ext_sel;
  logic [7:0] cpu_byte;
  logic [7:0] sent_byte;
  logic cap;

  // a request is only taken while overhead work is on
  assign take = add_req_valid_i && add_req_ready_o && en_ff;

  // pick the per-slot select and processor value
  always_comb begin
    ext_sel = 1'b0;
    cpu_byte = BYTE_RST;
    unique case (add_req_i.slot)
      POH_SLOT_GA: begin
        ext_sel = ext_growth_a_sel_i;
        cpu_byte = growth_a_ff;
      end
      POH_SLOT_GB: begin
        ext_sel = ext_growth_b_sel_i;
        cpu_byte = growth_b_ff;
      end
      POH_SLOT_GC: begin
        ext_sel = ext_growth_c_sel_i;
        cpu_byte = growth_c_ff;
      end
      POH_SLOT_TRACE: begin
        ext_sel = ext_trace_sel_i;
        cpu_byte = trace_mem[trace_ptr_ff];
      end
      default: begin
        ext_sel = 1'b0;
        cpu_byte = BYTE_RST;
      end
    endcase
  end

  // external byte wins when selected; capture the same byte sent
  assign sent_byte = ext_sel ? add_req_i.ext_byte : cpu_byte;
  assign cap = take && ext_sel && overhead_capture_to_ram_i;

  // ---------------------------------------------------------------
  // growth byte registers
  // ---------------------------------------------------------------
  // capture beats a same-cycle processor write: the stored value
  // must match what left on the bus
  always_ff @(posedge mclk_i) begin
    if (!rst_b_i) begin
      growth_a_ff <= BYTE_RST;
      growth_b_ff <= BYTE_RST;
      growth_c_ff <= BYTE_RST;
    end else begin
      if (cap && add_req_i.slot == POH_SLOT_GA) begin
        growth_a_ff <= add_req_i.ext_byte;
      end else if (cpu_wr_i && cpu_addr_i == ADR_GROWTH_A) begin
        growth_a_ff <= cpu_wdata_i;
      end
      if (cap && add_req_i.slot == POH_SLOT_GB) begin
        growth_b_ff <= add_req_i.ext_byte;
      end else if (cpu_wr_i && cpu_addr_i == ADR_GROWTH_B) begin
        growth_b_ff <= cpu_wdata_i;
      end
      if (cap && add_req_i.slot == POH_SLOT_GC) begin
        growth_c_ff <= add_req_i.ext_byte;
      end else if (cpu_wr_i && cpu_addr_i == ADR_GROWTH_C) begin
        growth_c_ff <= cpu_wdata_i;
      end
    end
  end

  // expected label, processor written
  always_ff @(posedge mclk_i) begin
    if (!rst_b_i) begin
      exp_label_ff <= BYTE_RST;
    end else if (cpu_wr_i && cpu_addr_i == ADR_EXP_LABEL) begin
      exp_label_ff <= cpu_wdata_i;
    end
  end

  // ---------------------------------------------------------------
  // trace message store
  // ---------------------------------------------------------------
  logic trace_cap;

  assign trace_cap = cap && add_req_i.slot == POH_SLOT_TRACE;

  // no reset on the array; software loads it before use
  always_ff @(posedge mclk_i) begin
    if (trace_cap) begin
      trace_mem[trace_ptr_ff] <= add_req_i.ext_byte;
    end else if (cpu_wr_i && trace_hit) begin
      trace_mem[trace_wofs] <= cpu_wdata_i;
    end
  end

  // short message wraps after the first sixteen locations
  always_comb begin
    nxt_trace_ptr = trace_ptr_ff + 1'b1;
    if (trace_length_select_i &&
        trace_ptr_ff >= PW'(TRACE_SHORT - 1)) begin
      nxt_trace_ptr = '0;
    end else if (trace_ptr_ff == PW'(TRACE_DEPTH - 1)) begin
      nxt_trace_ptr = '0;
    end
  end

  // one step per trace slot, no fixed start point
  always_ff @(posedge mclk_i) begin
    if (!rst_b_i) begin
      trace_ptr_ff <= '0;
    end else if (take && add_req_i.slot == POH_SLOT_TRACE) begin
      trace_ptr_ff <= nxt_trace_ptr;
    end
  end

  // ---------------------------------------------------------------
  // two-entry output buffer
  // ---------------------------------------------------------------
  poh_add_out_t buf_ff [2];
  logic [1:0] buf_cnt_ff;
  logic buf_rd_ff;
  logic push;
  logic pop;
  poh_add_out_t push_word;

  // bit 7 of the byte leaves first on the add bus
  assign push_word = '{slot: add_req_i.slot, data: sent_byte};
  assign push = take && add_req_i.slot != POH_SLOT_NONE;
  assign pop = add_out_valid_o && add_out_ready_i;
  // stall the frame source when both entries are full
  assign add_req_ready_o = (buf_cnt_ff != 2'd2);
  assign add_out_valid_o = (buf_cnt_ff != 2'd0);
  assign add_out_o = buf_ff[buf_rd_ff];

  // write slot is read pointer plus count, modulo two
  always_ff @(posedge mclk_i) begin
    if (!rst_b_i) begin
      buf_ff[0] <= '0;
      buf_ff[1] <= '0;
    end else if (push) begin
      buf_ff[buf_rd_ff ^ buf_cnt_ff[0]] <= push_word;
    end
  end

  // occupancy and read pointer
  always_ff @(posedge mclk_i) begin
    if (!rst_b_i) begin
      buf_cnt_ff <= 2'd0;
      buf_rd_ff <= 1'b0;
    end else begin
      if (push && !pop) begin
        buf_cnt_ff <= buf_cnt_ff + 2'd1;
      end else if (pop && !push) begin
        buf_cnt_ff <= buf_cnt_ff - 2'd1;
      end
      if (pop) begin
        buf_rd_ff <= ~buf_rd_ff;
      end
    end
  end

  // ---------------------------------------------------------------
  // drop side capture
  // ---------------------------------------------------------------
  logic [7:0] rx_parity_ff;
  logic [7:0] rx_label_ff;
  logic [7:0] rx_status_ff;
  logic drop_ok;

  assign drop_ok = drop_i.valid && en_ff;

  // bytes land as carried: frame bit 1 in register bit 7
  always_ff @(posedge mclk_i) begin
    if (!rst_b_i) begin
      rx_parity_ff <= BYTE_RST;
      rx_label_ff <= BYTE_RST;
      rx_status_ff <= BYTE_RST;
    end else if (drop_ok) begin
      if (drop_i.kind == POH_RX_PARITY) begin
        rx_parity_ff <= drop_i.data;
      end
      if (drop_i.kind == POH_RX_LABEL) begin
        rx_label_ff <= drop_i.data;
      end
      if (drop_i.kind == POH_RX_STATUS) begin
        rx_status_ff <= drop_i.data;
      end
    end
  end

  // status fields broken out for the alarm logic
  assign rx_febe_o = rx_status_ff[STAT_FEBE_HI:STAT_FEBE_LO];
  assign rx_rdi_o = rx_status_ff[STAT_RDI];

  // mismatch tracks the latest label against the expected one
  always_ff @(posedge mclk_i) begin
    if (!rst_b_i) begin
      label_mismatch_o <= 1'b0;
    end else begin
      label_mismatch_o <= (rx_label_ff != exp_label_ff);
    end
  end

  // ---------------------------------------------------------------
  // parity error counters
  // ---------------------------------------------------------------
  logic [7:0] par_diff;
  logic [3:0] bit_errs;
  logic [15:0] biterr_ff;
  logic [7:0] blkerr_ff;
  logic [16:0] bit_sum;

  assign par_diff = drop_i.data ^ drop_i.calc_parity;

  // count differing bits in the parity byte
  always_comb begin
    bit_errs = 4'd0;
    for (int i = 0; i < 8; i++) begin
      bit_errs = bit_errs + 4'(par_diff[i]);
    end
  end

  assign bit_sum = {1'b0, biterr_ff} + {13'd0, bit_errs};

  // counters saturate rather than wrap, so overflow is visible
  always_ff @(posedge mclk_i) begin
    if (!rst_b_i) begin
      biterr_ff <= BITERR_RST;
      blkerr_ff <= BYTE_RST;
    end else if (drop_ok && drop_i.kind == POH_RX_PARITY &&
                 bit_errs != 4'd0) begin
      biterr_ff <= bit_sum[16] ? BITERR_MAX : bit_sum[15:0];
      if (blkerr_ff != BLKERR_MAX) begin
        blkerr_ff <= blkerr_ff + 8'd1;
      end
    end
  end

  // ---------------------------------------------------------------
  // processor read mux
  // ---------------------------------------------------------------
  logic [7:0] nxt_rdata;

  // writes to read-only locations fall through with no effect
  always_comb begin
    nxt_rdata = BYTE_RST;
    if (trace_hit) begin
      nxt_rdata = trace_mem[trace_wofs];
    end else begin
      unique case (cpu_addr_i)
        ADR_GROWTH_A: nxt_rdata = growth_a_ff;
        ADR_GROWTH_B: nxt_rdata = growth_b_ff;
        ADR_GROWTH_C: nxt_rdata = growth_c_ff;
        ADR_EXP_LABEL: nxt_rdata = exp_label_ff;
        ADR_RX_PARITY: nxt_rdata = rx_parity_ff;
        ADR_RX_LABEL: nxt_rdata = rx_label_ff;
        ADR_RX_STATUS: nxt_rdata = rx_status_ff;
        ADR_BITERR_LO: nxt_rdata = biterr_ff[7:0];
        ADR_BITERR_HI: nxt_rdata = biterr_ff[15:8];
        ADR_BLKERR: nxt_rdata = blkerr_ff;
        default: nxt_rdata = BYTE_RST;
      endcase
    end
  end

  // read data registered one cycle after the strobe
  always_ff @(posedge mclk_i) begin
    if (!rst_b_i) begin
      cpu_rdata_o <= BYTE_RST;
    end else if (cpu_rd_i) begin
      cpu_rdata_o <= nxt_rdata;
    end
  end
endmodule
`default_nettype wire

// ===== sim/poh_bank_sva.sv
// checker: port-level properties of the overhead byte bank
`timescale 1ns/1ps
`default_nettype none
module poh_bank_sva (
  input wire logic mclk_i,
  input wire logic rst_b_i,
  input wire logic [7:0] cpu_addr_i,
  input wire logic [7:0] cpu_wdata_i,
  input wire logic cpu_wr_i,
  input wire logic cpu_rd_i,
  input wire logic [7:0] cpu_rdata_o,
  input wire logic ext_growth_a_sel_i,
  input wire logic ext_growth_b_sel_i,
  input wire logic ext_growth_c_sel_i,
  input wire logic ext_trace_sel_i,
  input wire logic overhead_disable_pin_i,
  input wire poh_pkg::poh_add_req_t add_req_i,
  input wire logic add_req_valid_i,
  input wire logic add_req_ready_o,
  input wire poh_pkg::poh_add_out_t add_out_o,
  input wire logic add_out_valid_o,
  input wire logic add_out_ready_i,
  input wire poh_pkg::poh_drop_t drop_i,
  input wire logic label_mismatch_o,
  input wire logic [3:0] rx_febe_o,
  input wire logic rx_rdi_o
);
  import poh_pkg::*;
  // ---------------------------------------------------------------
  // helper state
  // ---------------------------------------------------------------
  logic [2:0] pin_hist_ff;
  logic [7:0] exp_label_ff;
  logic on_w, off_w, sel_w, take_w, lbl_w;
  // pin history: the design syncs the pin, so judge only settled spans
  always_ff @(posedge mclk_i) begin
    pin_hist_ff <= {pin_hist_ff[1:0], overhead_disable_pin_i};
  end
  // shadow of the expected label, written by the processor
  always_ff @(posedge mclk_i) begin
    if (!rst_b_i) begin
      exp_label_ff <= BYTE_RST;
    end else if (cpu_wr_i && cpu_addr_i == ADR_EXP_LABEL) begin
      exp_label_ff <= cpu_wdata_i;
    end
  end
  // decoded conditions at the ports
  assign on_w = overhead_disable_pin_i && (&pin_hist_ff);
  assign off_w = !overhead_disable_pin_i && !(|pin_hist_ff);
  assign take_w = add_req_valid_i && add_req_ready_o;
  assign lbl_w = drop_i.valid && drop_i.kind == POH_RX_LABEL;
  assign sel_w = (add_req_i.slot == POH_SLOT_GA && ext_growth_a_sel_i)
    || (add_req_i.slot == POH_SLOT_GB && ext_growth_b_sel_i)
    || (add_req_i.slot == POH_SLOT_GC && ext_growth_c_sel_i)
    || (add_req_i.slot == POH_SLOT_TRACE && ext_trace_sel_i);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rst_b_i);
  a_rdata_hold: assert property (!cpu_rd_i |=> $stable(cpu_rdata_o))
    else $error("read data moved without a read");
  a_unmapped_zero: assert property (
    cpu_rd_i && cpu_addr_i == 8'h00 |=> cpu_rdata_o == 8'h00)
    else $error("unmapped read not zero");
  a_ext_pass: assert property (
    take_w && on_w && sel_w && !add_out_valid_o |=> add_out_valid_o
    && add_out_o.data == $past(add_req_i.ext_byte))
    else $error("external byte not passed through");
  a_off_silent: assert property (
    off_w && !add_out_valid_o |=> !add_out_valid_o)
    else $error("byte emitted while disabled");
  a_out_hold: assert property (
    add_out_valid_o && !add_out_ready_i |=> add_out_valid_o
    && $stable(add_out_o))
    else $error("stalled add byte changed");
  a_label_differs: assert property (
    on_w && lbl_w && drop_i.data != exp_label_ff ##1 !lbl_w
    |=> label_mismatch_o)
    else $error("label mismatch not flagged");
  a_label_agrees: assert property (
    on_w && lbl_w && drop_i.data == exp_label_ff ##1 !lbl_w
    |=> !label_mismatch_o)
    else $error("label mismatch flagged wrongly");
  a_status_fields: assert property (
    on_w && drop_i.valid && drop_i.kind == POH_RX_STATUS
    |=> rx_febe_o == $past(drop_i.data[7:4])
    && rx_rdi_o == $past(drop_i.data[3]))
    else $error("status fields wrong");
  a_slot_kept: assert property (
    take_w && on_w && add_req_i.slot != POH_SLOT_NONE && !add_out_valid_o
    |=> add_out_valid_o && add_out_o.slot == $past(add_req_i.slot))
    else $error("add byte lost its slot");
  a_none_dropped: assert property (
    take_w && add_req_i.slot == POH_SLOT_NONE && !add_out_valid_o
    |=> !add_out_valid_o)
    else $error("empty slot reached the add bus");
endmodule
bind poh_bank poh_bank_sva poh_bank_sva_i (
  .mclk_i, .rst_b_i, .cpu_addr_i, .cpu_wdata_i, .cpu_wr_i, .cpu_rd_i,
  .cpu_rdata_o, .ext_growth_a_sel_i, .ext_growth_b_sel_i,
  .ext_growth_c_sel_i, .ext_trace_sel_i, .overhead_disable_pin_i,
  .add_req_i, .add_req_valid_i, .add_req_ready_o, .add_out_o,
  .add_out_valid_o, .add_out_ready_i, .drop_i, .label_mismatch_o,
  .rx_febe_o, .rx_rdi_o);
`default_nettype wire

// ===== sim/poh_far_end.sv
// far-end model: add-bus sink and overhead enable pin driver
`timescale 1ns/1ps
`default_nettype none
module poh_far_end (
  input wire logic mclk_i,
  input wire logic stall_i,
  input wire logic en_i,
  input wire poh_pkg::poh_add_out_t add_out_i,
  input wire logic add_out_valid_i,
  output logic add_out_ready_o,
  output logic overhead_disable_pin_o
);
  // ---------------------------------------------------------------
  // sink
  // ---------------------------------------------------------------
  logic [7:0] got[$];
  // pin high enables processing, despite its name
  assign overhead_disable_pin_o = en_i;
  // stalls on request so the two-entry buffer fills
  assign add_out_ready_o = !stall_i;
  // every accepted byte is queued for the bench to judge
  always @(posedge mclk_i) begin
    if (add_out_valid_i && add_out_ready_o) begin
      got.push_back(add_out_i.data);
    end
  end
endmodule
`default_nettype wire

// ===== sim/poh_bank_bench.sv
// self-checking bench for the overhead byte bank
`timescale 1ns/1ps
`default_nettype none
module poh_bank_bench;
  import poh_pkg::*;
  // ---------------------------------------------------------------
  // signals and instances
  // ---------------------------------------------------------------
  logic mclk_i, rst_b_i, cpu_wr_i, cpu_rd_i, stall, en, pin, mis, rdi;
  logic [7:0] cpu_addr_i, cpu_wdata_i, cpu_rdata_o, v, w;
  logic [2:0] gsel;
  logic tsel, cap, tlen, add_req_valid_i, add_req_ready_o;
  logic add_out_valid_o, add_out_ready_i;
  logic [3:0] febe;
  poh_add_req_t add_req_i;
  poh_add_out_t add_out_o;
  poh_drop_t drop_i;
  int fail_count, checked;
  poh_bank poh_bank_i (
    .mclk_i, .rst_b_i, .cpu_addr_i, .cpu_wdata_i, .cpu_wr_i, .cpu_rd_i,
    .cpu_rdata_o, .ext_growth_a_sel_i(gsel[0]),
    .ext_growth_b_sel_i(gsel[1]), .ext_growth_c_sel_i(gsel[2]),
    .ext_trace_sel_i(tsel), .overhead_capture_to_ram_i(cap),
    .trace_length_select_i(tlen), .overhead_disable_pin_i(pin),
    .add_req_i, .add_req_valid_i, .add_req_ready_o, .add_out_o,
    .add_out_valid_o, .add_out_ready_i, .drop_i,
    .label_mismatch_o(mis), .rx_febe_o(febe), .rx_rdi_o(rdi));
  poh_far_end poh_far_end_i (
    .mclk_i, .stall_i(stall), .en_i(en), .add_out_i(add_out_o),
    .add_out_valid_i(add_out_valid_o), .add_out_ready_o(add_out_ready_i),
    .overhead_disable_pin_o(pin));
  always #5 mclk_i = ~mclk_i;
  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  task automatic cmp(input logic [7:0] g, input logic [7:0] e);
    checked++;
    if (g !== e) begin
      fail_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // strobes drop for a cycle so back-to-back calls never collide
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    cpu_addr_i <= a;
    cpu_wdata_i <= d;
    cpu_wr_i <= 1'b1;
    @(posedge mclk_i);
    cpu_wr_i <= 1'b0;
    @(posedge mclk_i);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    cpu_addr_i <= a;
    cpu_rd_i <= 1'b1;
    @(posedge mclk_i);
    cpu_rd_i <= 1'b0;
    @(posedge mclk_i);
    cmp(cpu_rdata_o, e);
  endtask
  // ready is judged at the falling edge, where it has settled
  task automatic add(input poh_slot_t s, input logic [7:0] e);
    add_req_i <= '{slot: s, ext_byte: e};
    add_req_valid_i <= 1'b1;
    @(negedge mclk_i);
    while (add_req_ready_o !== 1'b1) @(negedge mclk_i);
    @(posedge mclk_i);
    add_req_valid_i <= 1'b0;
    @(posedge mclk_i);
  endtask
  // idle drop data is inverted so stale bytes cannot pass
  task automatic drop(input poh_rx_kind_t k, input logic [7:0] d,
                      input logic [7:0] c);
    drop_i <= '{1'b1, k, d, c};
    @(posedge mclk_i);
    drop_i <= '{1'b0, k, ~d, ~c};
    @(posedge mclk_i);
  endtask
  task automatic take(output logic [7:0] g);
    repeat (20) if (poh_far_end_i.got.size() == 0) @(posedge mclk_i);
    g = (poh_far_end_i.got.size() > 0) ? poh_far_end_i.got.pop_front()
      : 8'hxx;
  endtask
  task automatic end_of_test;
    $display("checked=%0d fail_count=%0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // watchdog against a hung handshake
  initial begin
    repeat (20000) @(posedge mclk_i);
    fail_count++;
    end_of_test;
  end
  // ---------------------------------------------------------------
  // test sequence
  // ---------------------------------------------------------------
  initial begin
    mclk_i = 1'b0;
    rst_b_i = 1'b0;
    {cpu_wr_i, cpu_rd_i, stall, en, gsel, tsel, cap, tlen} = '0;
    {add_req_valid_i, cpu_addr_i, cpu_wdata_i} = '0;
    add_req_i = '0;
    drop_i = '0;
    fail_count = 0;
    checked = 0;
    repeat (16) @(posedge mclk_i);
    rst_b_i <= 1'b1;
    en <= 1'b1;
    repeat (4) @(posedge mclk_i);
    for (int i = 0; i < 3; i++) wr(ADR_GROWTH_A + 8'(i), 8'hA0 + 8'(i));
    wr(ADR_EXP_LABEL, 8'h11);
    wr(ADR_RX_PARITY, 8'h55);
    rd(ADR_RX_PARITY, 8'h00);
    rd(8'h00, 8'h00);
    // growth bytes: processor, external, then external with capture
    for (int i = 0; i < 3; i++) begin
      add(poh_slot_t'(3'(i + 1)), 8'h5A);
      take(v);
      cmp(v, 8'hA0 + 8'(i));
      gsel <= 3'b111;
      add(poh_slot_t'(3'(i + 1)), 8'hC0 + 8'(i));
      take(v);
      cmp(v, 8'hC0 + 8'(i));
      rd(ADR_GROWTH_A + 8'(i), 8'hA0 + 8'(i));
      cap <= 1'b1;
      add(poh_slot_t'(3'(i + 1)), 8'hD0 + 8'(i));
      take(v);
      cmp(v, 8'hD0 + 8'(i));
      rd(ADR_GROWTH_A + 8'(i), 8'hD0 + 8'(i));
      {gsel, cap} <= '0;
    end
    // trace, long then short: start is free, order must wrap
    for (int i = 0; i < 64; i++) wr(ADR_TRACE_LO + 8'(i), 8'(i));
    for (int m = 0; m < 2; m++) begin
      tlen <= m[0];
      for (int i = 0; i <= (m ? 16 : 64); i++) add(POH_SLOT_TRACE, 8'hEE);
      take(v);
      for (int i = 1; i <= (m ? 16 : 64); i++) begin
        take(w);
        cmp(w, (v + 8'(i)) & (m ? 8'h0F : 8'h3F));
      end
    end
    {tsel, cap} <= 2'b11;
    add(POH_SLOT_TRACE, 8'h77);
    take(w);
    cmp(w, 8'h77);
    rd(ADR_TRACE_LO + ((v + 8'h01) & 8'h0F), 8'h77);
    // external without capture leaves the store alone
    {tsel, cap} <= 2'b10;
    add(POH_SLOT_TRACE, 8'h66);
    take(w);
    cmp(w, 8'h66);
    rd(ADR_TRACE_LO + ((v + 8'h02) & 8'h0F), (v + 8'h02) & 8'h0F);
    {tsel, cap} <= 2'b00;
    // drop side captures, label check and error counters
    drop(POH_RX_LABEL, 8'h22, 8'h00);
    rd(ADR_RX_LABEL, 8'h22);
    cmp({7'h0, mis}, 8'h01);
    drop(POH_RX_LABEL, 8'h11, 8'h00);
    @(posedge mclk_i); // mismatch lags the capture by a cycle
    cmp({7'h0, mis}, 8'h00);
    drop(POH_RX_STATUS, 8'hA8, 8'h00);
    rd(ADR_RX_STATUS, 8'hA8);
    cmp({febe, rdi, 3'h0}, 8'hA8);
    drop(POH_RX_PARITY, 8'h0F, 8'h0E);
    drop(POH_RX_PARITY, 8'h3C, 8'h3C);
    drop(POH_RX_PARITY, 8'hFF, 8'h00);
    rd(ADR_RX_PARITY, 8'hFF);
    rd(ADR_BITERR_LO, 8'h09);
    rd(ADR_BITERR_HI, 8'h00);
    rd(ADR_BLKERR, 8'h02);
    // 256 more bit errors carry into the high byte
    repeat (32) drop(POH_RX_PARITY, 8'hFF, 8'h00);
    rd(ADR_BITERR_LO, 8'h09);
    rd(ADR_BITERR_HI, 8'h01);
    rd(ADR_BLKERR, 8'h22);
    wr(ADR_BITERR_LO, 8'h55);
    rd(ADR_BITERR_LO, 8'h09);
    // pin low: traffic is consumed but has no effect
    en <= 1'b0;
    repeat (4) @(posedge mclk_i);
    drop(POH_RX_LABEL, 8'h33, 8'h00);
    add(POH_SLOT_GA, 8'h44);
    repeat (8) @(posedge mclk_i);
    rd(ADR_RX_LABEL, 8'h11);
    cmp(8'(poh_far_end_i.got.size()), 8'h00);
    en <= 1'b1;
    repeat (4) @(posedge mclk_i);
    // sink stalls: an empty slot is dropped, two entries fill the buffer
    stall <= 1'b1;
    add(POH_SLOT_NONE, 8'h45);
    add(POH_SLOT_GB, 8'h00);
    add(POH_SLOT_GC, 8'h00);
    @(negedge mclk_i);
    cmp({7'h0, add_req_ready_o}, 8'h00);
    @(posedge mclk_i);
    stall <= 1'b0;
    take(v);
    cmp(v, 8'hD1);
    take(v);
    cmp(v, 8'hD2);
    end_of_test;
  end
endmodule
`default_nettype wire
